// ==== core/fpec_byte_reg.sv ====
// one 8-bit interface register with write and clear-on-completion
`timescale 1ns/1ps
module fpec_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] CLR_MASK  = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       clr,
  output logic      [7:0] q
);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= wr_data;
    end else if (clr) begin
      q <= q & ~CLR_MASK;
    end
  end

endmodule

// ==== core/fpec_defs.svh ====
// offsets, field positions, reset values and counts of the flash control block
//
// Contract
// - Downloaded routine stays valid for repeat runs
// - Enable bit zero: shared pin is port
// - Internal flash write enable is always high
// - Registers reachable only while access enable set
// - Registers are 8 bits, byte accesses only
// - Reset returns every register to initial value
// - Status bit 7 shows write enable level
// - Monitor zero means hardware protection state
// - Bit 4 error flag, protection, reset clears
// - Any interrupt during operation sets error
// - Flash read during operation sets error
// - Sleep or standby during operation sets error
// - Each phase uses its own register subset
// - Mode inputs sampled to choose operating mode
// - Boot mode exchanges data over serial pins
// - Copy request with key, from RAM, starts download
`ifndef FPEC_DEFS_SVH
`define FPEC_DEFS_SVH

// ==========================================
// register offsets (byte addresses)
`define FPEC_OFF_CCS      8'h00
`define FPEC_OFF_PCS      8'h04
`define FPEC_OFF_ECS      8'h08
`define FPEC_OFF_KEY      8'h0C
`define FPEC_OFF_ASEL     8'h10
`define FPEC_OFF_DEST     8'h14
`define FPEC_OFF_STAT     8'h18
`define FPEC_OFF_PCTL     8'h1C
`define FPEC_OFF_RUN      8'h20

// ==========================================
// fields and values
`define FPEC_CCS_FWE      7
`define FPEC_CCS_ERR      4
`define FPEC_CCS_COPY     0
`define FPEC_CCS_RSV_MASK 8'h6E
`define FPEC_SEL_BIT      0
`define FPEC_PCTL_PFE     0
`define FPEC_RUN_PROG     0
`define FPEC_RUN_ERASE    1
`define FPEC_RUN_END      2
`define FPEC_KEY_VALUE    8'hA5
`define FPEC_REG_RESET    8'h00
`define FPEC_SEL_CLR_MASK 8'h01
`define FPEC_MD_BOOT      2'h0
`define FPEC_MD_UBOOT     2'h1
`define FPEC_MD_UPROG     2'h2
`define FPEC_DL_CYCLES    64
// 100 us of reset at 5 ns per cycle, owed by the system after an error
`define FPEC_ERR_RST_CYCLES 20000

// ==========================================
// bus answers
`define FPEC_RESP_OKAY    2'h0
`define FPEC_RESP_SLVERR  2'h2
`define FPEC_RESP_DECERR  2'h3

`endif

// ==== core/fpec_pkg.sv ====
// types shared by the flash control block
package fpec_pkg;

  // ==========================================
  // sequencer phases and operating modes
  typedef enum logic [1:0] {ST_IDLE, ST_DOWNLOAD, ST_PROGRAM, ST_ERASE} fpec_state_t;
  typedef enum logic [1:0] {MODE_BOOT, MODE_USER_BOOT, MODE_USER_PROG, MODE_USER} fpec_mode_t;

  // ==========================================
  // cpu events watched while the array is busy
  typedef struct packed {
    logic irq;
    logic nmi;
    logic flash_read;
    logic sleep;
  } fpec_evt_t;

endpackage

// ==== core/fpec_top.sv ====
// flash program/erase control: axi4-lite registers, download and error protection
`timescale 1ns/1ps
`include "fpec_defs.svh"
module fpec_top #(
  parameter int DL_CYCLES = `FPEC_DL_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                flash_access_enable_bit,
  input  wire logic                cpu_in_ram,
  input  wire fpec_pkg::fpec_evt_t cpu_events,
  input  wire logic                mode_select_high,
  input  wire logic                mode_select_low,
  input  wire logic                shared_port_pin,
  output logic                     port_pin_data,
  input  wire logic                boot_serial_receive,
  output logic                     boot_serial_transmit,
  input  wire logic                sci_tx,
  output logic                     sci_rx,
  output logic                     download_busy,
  output logic                     operation_busy,
  output logic                     error_protect
);
  import fpec_pkg::*;

  localparam logic [7:0] RV = `FPEC_REG_RESET;
  localparam logic [7:0] SM = `FPEC_SEL_CLR_MASK;
  localparam int unsigned DL_LAST = DL_CYCLES - 1;

  // ==========================================
  // state
  fpec_state_t state_q, state_d;
  fpec_mode_t  mode_q;
  logic        mode_valid_q;
  logic [15:0] dl_cnt_q;
  logic        err_q;
  logic [7:0]  ccs_rsv_q;
  logic        loaded_prog_q;
  logic        loaded_erase_q;
  logic [7:0]  pcs_q, ecs_q, key_q, asel_q, dest_q, pctl_q;
  logic        aw_got_q, w_got_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        rd_ccs_q;
  logic        rd_ok_q;

  // ==========================================
  // internal write enable and pin sharing
  wire fwe_int     = 1'b1;
  wire pin_fn_en   = pctl_q[`FPEC_PCTL_PFE];
  wire hw_protect  = ~fwe_int;
  wire on_board_ok = mode_valid_q & (mode_q != MODE_USER);
  wire in_boot     = mode_valid_q & (mode_q == MODE_BOOT);
  wire run_active  = (state_q == ST_PROGRAM) || (state_q == ST_ERASE);
  wire dl_active   = (state_q == ST_DOWNLOAD);
  wire key_ok      = (key_q == `FPEC_KEY_VALUE);

  // ==========================================
  // write decode
  wire       wr_do    = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire       wr_byte  = (w_strb_q == 4'h1);
  wire       wr_allow = flash_access_enable_bit & wr_byte;
  wire [7:0] wd       = w_data_q[7:0];
  wire       a_ccs    = (aw_addr_q == `FPEC_OFF_CCS);
  wire       a_pcs    = (aw_addr_q == `FPEC_OFF_PCS);
  wire       a_ecs    = (aw_addr_q == `FPEC_OFF_ECS);
  wire       a_key    = (aw_addr_q == `FPEC_OFF_KEY);
  wire       a_asel   = (aw_addr_q == `FPEC_OFF_ASEL);
  wire       a_dest   = (aw_addr_q == `FPEC_OFF_DEST);
  wire       a_stat   = (aw_addr_q == `FPEC_OFF_STAT);
  wire       a_pctl   = (aw_addr_q == `FPEC_OFF_PCTL);
  wire       a_run    = (aw_addr_q == `FPEC_OFF_RUN);
  wire       a_hit    = a_ccs | a_pcs | a_ecs | a_key | a_asel | a_dest | a_stat | a_pctl | a_run;
  // download-phase registers are frozen once a phase is under way
  wire       dl_regs  = a_ccs | a_pcs | a_ecs | a_dest;
  wire       phase_ok = ~(dl_regs & (state_q != ST_IDLE));
  wire       wr_ok    = wr_do & a_hit & wr_allow & phase_ok & ~a_stat;
  wire [1:0] wr_resp  = !a_hit ? `FPEC_RESP_DECERR :
                        (wr_allow & phase_ok & ~a_stat) ? `FPEC_RESP_OKAY : `FPEC_RESP_SLVERR;

  // ==========================================
  // sequencer requests
  wire one_sel   = pcs_q[`FPEC_SEL_BIT] ^ ecs_q[`FPEC_SEL_BIT];
  wire copy_req  = wr_ok & a_ccs & wd[`FPEC_CCS_COPY];
  wire dl_start  = copy_req & key_ok & cpu_in_ram & one_sel & ~err_q;
  wire dl_done   = dl_active && (dl_cnt_q == 16'(DL_LAST));
  wire run_ok    = (state_q == ST_IDLE) & key_ok & fwe_int & ~err_q & on_board_ok;
  wire prog_go   = wr_ok & a_run & wd[`FPEC_RUN_PROG] & run_ok & loaded_prog_q;
  wire erase_go  = wr_ok & a_run & wd[`FPEC_RUN_ERASE] & ~wd[`FPEC_RUN_PROG] & run_ok
                   & loaded_erase_q;
  wire run_end   = wr_ok & a_run & wd[`FPEC_RUN_END] & run_active;
  wire evt_any   = cpu_events.irq | cpu_events.nmi;
  wire err_event = run_active & (evt_any | cpu_events.flash_read | cpu_events.sleep);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (dl_start) begin
          state_d = ST_DOWNLOAD;
        end else if (prog_go) begin
          state_d = ST_PROGRAM;
        end else if (erase_go) begin
          state_d = ST_ERASE;
        end
      end
      ST_DOWNLOAD: begin
        if (dl_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_PROGRAM, ST_ERASE: begin
        // an error aborts the operation at once
        if (err_event || run_end) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      dl_cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      dl_cnt_q <= dl_active ? dl_cnt_q + 16'h0001 : 16'h0000;
    end
  end

  // ==========================================
  // error flag, routine memory, reserved bits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      err_q <= 1'b0;
      loaded_prog_q <= 1'b0;
      loaded_erase_q <= 1'b0;
      ccs_rsv_q <= RV;
    end else begin
      err_q <= err_q | err_event;
      loaded_prog_q <= loaded_prog_q | (dl_done & pcs_q[`FPEC_SEL_BIT]);
      loaded_erase_q <= loaded_erase_q | (dl_done & ecs_q[`FPEC_SEL_BIT]);
      if (wr_ok && a_ccs) begin
        ccs_rsv_q <= wd & `FPEC_CCS_RSV_MASK;
      end
    end
  end

  // ==========================================
  // mode pins caught on the first edge after reset release
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_valid_q <= 1'b0;
      mode_q <= MODE_USER;
    end else if (!mode_valid_q) begin
      mode_valid_q <= 1'b1;
      unique case ({mode_select_high, mode_select_low})
        `FPEC_MD_BOOT:  mode_q <= MODE_BOOT;
        `FPEC_MD_UBOOT: mode_q <= MODE_USER_BOOT;
        `FPEC_MD_UPROG: mode_q <= MODE_USER_PROG;
        default:        mode_q <= MODE_USER;
      endcase
    end
  end

  // ==========================================
  // pins: port function, boot serial channel
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_pin_data <= 1'b0;
      boot_serial_transmit <= 1'b1;
      sci_rx <= 1'b1;
    end else begin
      port_pin_data <= pin_fn_en ? 1'b0 : shared_port_pin;
      boot_serial_transmit <= in_boot ? sci_tx : 1'b1;
      sci_rx <= in_boot ? boot_serial_receive : 1'b1;
    end
  end

  // ==========================================
  // interface registers
  fpec_byte_reg #(.RESET_VAL(RV), .CLR_MASK(SM)) u_pcs (
    .clock(clock), .rst_n(rst_n), .wr_en(wr_ok & a_pcs), .wr_data(wd), .clr(dl_done), .q(pcs_q));
  fpec_byte_reg #(.RESET_VAL(RV), .CLR_MASK(SM)) u_ecs (
    .clock(clock), .rst_n(rst_n), .wr_en(wr_ok & a_ecs), .wr_data(wd), .clr(dl_done), .q(ecs_q));
  fpec_byte_reg #(.RESET_VAL(RV), .CLR_MASK(RV)) u_key (
    .clock(clock), .rst_n(rst_n), .wr_en(wr_ok & a_key), .wr_data(wd), .clr(1'b0), .q(key_q));
  fpec_byte_reg #(.RESET_VAL(RV), .CLR_MASK(RV)) u_asel (
    .clock(clock), .rst_n(rst_n), .wr_en(wr_ok & a_asel), .wr_data(wd), .clr(1'b0), .q(asel_q));
  fpec_byte_reg #(.RESET_VAL(RV), .CLR_MASK(RV)) u_dest (
    .clock(clock), .rst_n(rst_n), .wr_en(wr_ok & a_dest), .wr_data(wd), .clr(1'b0), .q(dest_q));
  fpec_byte_reg #(.RESET_VAL(RV), .CLR_MASK(RV)) u_pctl (
    .clock(clock), .rst_n(rst_n), .wr_en(wr_ok & a_pctl), .wr_data(wd), .clr(1'b0), .q(pctl_q));

  // ==========================================
  // read mux
  wire [7:0] ccs_rd  = {fwe_int, ccs_rsv_q[6:5], err_q, ccs_rsv_q[3:1], 1'b0};
  wire [7:0] stat_rd = {1'b0, hw_protect, mode_q, err_q, loaded_erase_q | loaded_prog_q,
                        dl_active, run_active};
  wire       r_ccs   = (s_axi_araddr == `FPEC_OFF_CCS);
  wire       r_hit   = r_ccs | (s_axi_araddr == `FPEC_OFF_PCS) | (s_axi_araddr == `FPEC_OFF_ECS)
                     | (s_axi_araddr == `FPEC_OFF_KEY) | (s_axi_araddr == `FPEC_OFF_ASEL)
                     | (s_axi_araddr == `FPEC_OFF_DEST) | (s_axi_araddr == `FPEC_OFF_STAT)
                     | (s_axi_araddr == `FPEC_OFF_PCTL) | (s_axi_araddr == `FPEC_OFF_RUN);
  wire [7:0] rd_mux  = r_ccs ? ccs_rd :
                       (s_axi_araddr == `FPEC_OFF_PCS)  ? pcs_q :
                       (s_axi_araddr == `FPEC_OFF_ECS)  ? ecs_q :
                       (s_axi_araddr == `FPEC_OFF_KEY)  ? key_q :
                       (s_axi_araddr == `FPEC_OFF_ASEL) ? asel_q :
                       (s_axi_araddr == `FPEC_OFF_DEST) ? dest_q :
                       (s_axi_araddr == `FPEC_OFF_STAT) ? stat_rd :
                       (s_axi_araddr == `FPEC_OFF_PCTL) ? pctl_q : 8'h00;
  wire       rd_ok   = r_hit & flash_access_enable_bit;
  wire       ar_take = s_axi_arvalid & s_axi_arready;

  // ==========================================
  // axi4-lite handshakes
  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPEC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_do) begin
        w_got_q <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FPEC_RESP_OKAY;
      rd_ccs_q <= 1'b0;
      rd_ok_q <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? {24'h000000, rd_mux} : 32'h0000_0000;
      s_axi_rresp <= !r_hit ? `FPEC_RESP_DECERR : (rd_ok ? `FPEC_RESP_OKAY : `FPEC_RESP_SLVERR);
      rd_ccs_q <= r_ccs;
      rd_ok_q <= rd_ok;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign download_busy  = dl_active;
  assign operation_busy = run_active;
  assign error_protect  = err_q;

  // ==========================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_CCS_FWE_MONITOR: assert property (
    s_axi_rvalid && rd_ccs_q && rd_ok_q |-> s_axi_rdata[7] && !s_axi_rdata[0])
    else $error("status read lost write enable level or copy bit");
  AST_ERR_STICKY: assert property ($past(err_q) |-> err_q)
    else $error("error flag cleared without reset");
  AST_ERR_ON_IRQ: assert property (
    run_active && (cpu_events.irq || cpu_events.nmi) |=> err_q && !run_active)
    else $error("interrupt during operation did not raise error");
  AST_ERR_ON_READ: assert property (run_active && cpu_events.flash_read |=> err_q)
    else $error("array read during operation did not raise error");
  AST_ERR_ON_SLEEP: assert property (run_active && cpu_events.sleep |=> err_q)
    else $error("sleep during operation did not raise error");
  AST_NO_START_IN_ERR: assert property (err_q |-> ##1 !run_active [*3])
    else $error("operation started under error protection");
  AST_GATED_READ: assert property (
    s_axi_rvalid && !rd_ok_q |-> s_axi_rdata == 32'h0000_0000 && s_axi_rresp != 2'h0)
    else $error("read answered while access disabled");
  AST_DL_COMPLETE: assert property (
    dl_start |=> dl_active [*8])
    else $error("download did not run after copy request");
  AST_DL_CLEARS_SEL: assert property (
    dl_done |=> !dl_active && pcs_q[0] == 1'b0 && ecs_q[0] == 1'b0)
    else $error("download completion left select bits set");
  AST_LOADED_KEPT: assert property ($past(loaded_prog_q) |-> loaded_prog_q)
    else $error("downloaded routine forgotten");
  AST_PORT_PIN: assert property (
    rst_n && !pin_fn_en |=> port_pin_data == $past(shared_port_pin))
    else $error("shared pin not passed as port");
  AST_BYTE_ONLY: assert property (
    wr_do && !wr_byte |=> s_axi_bvalid && s_axi_bresp != 2'h0)
    else $error("non-byte write accepted");
  AST_RESET_INIT: assert property (@(posedge clock) disable iff (1'b0)
    !rst_n |=> key_q == 8'h00 && pcs_q == 8'h00 && !err_q)
    else $error("register not at initial value after reset");

  COV_DOWNLOAD: cover property (dl_done);
  COV_PROGRAM:  cover property (prog_go);
  COV_REPEAT:   cover property (run_end ##[1:50] prog_go);
  COV_ERROR:    cover property (err_event);

endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
`include "fpec_defs.svh"
module tb_top;
  import fpec_pkg::*;
  localparam int DL = 8;
  logic        clock = 1'b0, rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] d;
  logic        acc_en = 1'b1, in_ram = 1'b1, md_hi = 1'b1, md_lo = 1'b0;
  logic        pin = 1'b0, rx_pin = 1'b1, sci_tx = 1'b1;
  logic        port_pin_data, sci_rx, tx_pin, download_busy, operation_busy, error_protect;
  fpec_evt_t   ev = '0;
  int          fails = 0, n_checks = 0;

  fpec_top #(.DL_CYCLES(DL)) dut (
    .clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_access_enable_bit(acc_en), .cpu_in_ram(in_ram), .cpu_events(ev),
    .mode_select_high(md_hi), .mode_select_low(md_lo), .shared_port_pin(pin),
    .port_pin_data(port_pin_data), .boot_serial_receive(rx_pin), .boot_serial_transmit(tx_pin),
    .sci_tx(sci_tx), .sci_rx(sci_rx), .download_busy(download_busy),
    .operation_busy(operation_busy), .error_protect(error_protect));

  always #2.5 clock = ~clock;

  // ==========================================
  // common tasks
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [1:0] md, input int hold = 3);
    @(posedge clock);
    rst_n <= 1'b0;
    md_hi <= md[1];
    md_lo <= md[0];
    repeat (hold) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  // ready and answer flags are registered, so their level at the falling edge is the one
  // sampled at the next rising edge
  task automatic axw(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s,
                     output logic [1:0] resp);
    logic ah, wh, bh;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h000000, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clock);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      resp = bresp;
      @(posedge clock);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ah, rh;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clock);
      ah = arvalid && arready;
      rh = rvalid && rready;
      v = rdata;
      resp = rresp;
      @(posedge clock);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    axw(a, v, 4'h1, r);
    chk(r, `FPEC_RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    axr(a, d, r);
    chk(d, {24'h000000, exp});
    chk(r, `FPEC_RESP_OKAY);
  endtask

  task automatic download(input logic [7:0] sel);
    int t;
    wr(`FPEC_OFF_KEY, `FPEC_KEY_VALUE);
    wr(sel, 8'h01);
    wr(`FPEC_OFF_CCS, 8'h01);
    chk(download_busy, 1'b1);
    t = 0;
    do begin
      @(negedge clock);
      t++;
    end while (download_busy === 1'b1 && t < DL + 8);
    @(posedge clock);
    chk(download_busy, 1'b0);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset_regs;
    do_reset(2'b10);
    rd(`FPEC_OFF_CCS, 8'h80);
    rd(`FPEC_OFF_STAT, 8'h20);
    wr(`FPEC_OFF_DEST, 8'h3C);
    wr(`FPEC_OFF_KEY, 8'h5A);
    rd(`FPEC_OFF_DEST, 8'h3C);
    wr(`FPEC_OFF_CCS, 8'h10);
    rd(`FPEC_OFF_CCS, 8'h80);
    do_reset(2'b10);
    rd(`FPEC_OFF_DEST, 8'h00);
    rd(`FPEC_OFF_KEY, 8'h00);
  endtask

  task automatic t_access;
    @(posedge clock);
    acc_en <= 1'b0;
    axw(`FPEC_OFF_KEY, 8'h11, 4'h1, r);
    chk(r, `FPEC_RESP_SLVERR);
    axr(`FPEC_OFF_CCS, d, r);
    chk(d, 32'h0);
    chk(r, `FPEC_RESP_SLVERR);
    acc_en <= 1'b1;
    rd(`FPEC_OFF_KEY, 8'h00);
    axw(`FPEC_OFF_KEY, 8'h11, 4'hF, r);
    chk(r, `FPEC_RESP_SLVERR);
    rd(`FPEC_OFF_KEY, 8'h00);
    axw(`FPEC_OFF_STAT, 8'h01, 4'h1, r);
    chk(r, `FPEC_RESP_SLVERR);
    axw(8'h24, 8'h01, 4'h1, r);
    chk(r, `FPEC_RESP_DECERR);
    axr(8'h24, d, r);
    chk(r, `FPEC_RESP_DECERR);
  endtask

  task automatic t_port;
    pin <= 1'b1;
    repeat (2) @(posedge clock);
    chk(port_pin_data, 1'b1);
    pin <= 1'b0;
    repeat (2) @(posedge clock);
    chk(port_pin_data, 1'b0);
    wr(`FPEC_OFF_PCTL, 8'h01);
    pin <= 1'b1;
    repeat (2) @(posedge clock);
    chk(port_pin_data, 1'b0);
  endtask

  task automatic t_repeat;
    do_reset(2'b10);
    wr(`FPEC_OFF_PCS, 8'h01);
    wr(`FPEC_OFF_CCS, 8'h01);
    chk(download_busy, 1'b0);
    download(`FPEC_OFF_PCS);
    rd(`FPEC_OFF_PCS, 8'h00);
    rd(`FPEC_OFF_STAT, 8'h24);
    ev <= 4'h8;
    @(posedge clock);
    ev <= '0;
    repeat (2) @(posedge clock);
    chk(error_protect, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(`FPEC_OFF_RUN, 8'h01);
      chk(operation_busy, 1'b1);
      wr(`FPEC_OFF_RUN, 8'h04);
      chk(operation_busy, 1'b0);
    end
  endtask

  task automatic t_error;
    for (int i = 0; i < 4; i++) begin
      do_reset(2'b10, error_protect ? `FPEC_ERR_RST_CYCLES : 3);
      download(i[0] ? `FPEC_OFF_ECS : `FPEC_OFF_PCS);
      wr(`FPEC_OFF_RUN, i[0] ? 8'h02 : 8'h01);
      chk(operation_busy, 1'b1);
      ev <= 4'h8 >> i;
      @(posedge clock);
      ev <= '0;
      repeat (2) @(posedge clock);
      chk(error_protect, 1'b1);
      chk(operation_busy, 1'b0);
      rd(`FPEC_OFF_CCS, 8'h90);
      // routine loaded and a select set: only the error flag can refuse these
      axw(`FPEC_OFF_RUN, i[0] ? 8'h02 : 8'h01, 4'h1, r);
      chk(operation_busy, 1'b0);
      wr(i[0] ? `FPEC_OFF_ECS : `FPEC_OFF_PCS, 8'h01);
      axw(`FPEC_OFF_CCS, 8'h01, 4'h1, r);
      chk(download_busy, 1'b0);
    end
    do_reset(2'b10, `FPEC_ERR_RST_CYCLES);
    chk(error_protect, 1'b0);
    rd(`FPEC_OFF_CCS, 8'h80);
  endtask

  task automatic t_modes;
    do_reset(2'b11);
    download(`FPEC_OFF_PCS);
    wr(`FPEC_OFF_RUN, 8'h01);
    chk(operation_busy, 1'b0);
    do_reset(2'b01);
    rd(`FPEC_OFF_STAT, 8'h10);
    download(`FPEC_OFF_PCS);
    wr(`FPEC_OFF_ASEL, 8'h01);
    rd(`FPEC_OFF_ASEL, 8'h01);
    wr(`FPEC_OFF_RUN, 8'h01);
    chk(operation_busy, 1'b1);
    do_reset(2'b00);
    rd(`FPEC_OFF_STAT, 8'h00);
    sci_tx <= 1'b0;
    rx_pin <= 1'b0;
    repeat (2) @(posedge clock);
    chk(tx_pin, 1'b0);
    chk(sci_rx, 1'b0);
    sci_tx <= 1'b1;
    rx_pin <= 1'b1;
    repeat (2) @(posedge clock);
    chk(tx_pin, 1'b1);
    chk(sci_rx, 1'b1);
    do_reset(2'b10);
    sci_tx <= 1'b0;
    repeat (2) @(posedge clock);
    chk(tx_pin, 1'b1);
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    t_reset_regs();
    t_access();
    t_port();
    t_repeat();
    t_error();
    t_modes();
    finish_test();
  end

  initial begin
    // four 100 us error resets dominate the run
    #450000;
    fails = fails + 1;
    finish_test();
  end
endmodule
